//--- src/fbpo_defines.vh
`ifndef FBPO_DEFINES_VH
`define FBPO_DEFINES_VH
// status codes
`define FBPO_ST_OK 2'h0
`define FBPO_ST_SBE 2'h1
`define FBPO_ST_GUARD 2'h1
`define FBPO_ST_DBE 2'h2
`define FBPO_ST_THRESH 2'h3
`define FBPO_ST_LOSS 2'h3
// geometry: addr = {sector[4:0], page[4:0], block[3:0], byte[2:0]}
`define FBPO_AW 17
`define FBPO_SEC_MSB 16
`define FBPO_SEC_LSB 12
`define FBPO_PG_MSB 11
`define FBPO_PG_LSB 7
`define FBPO_BLK_MSB 6
`define FBPO_BLK_LSB 3
`define FBPO_NPAGES 1024
`define FBPO_LAST_BLK 4'h7
`define FBPO_AUX_BLK 4'h8
// timing counts in clk_sys cycles
`define FBPO_BLK_RD_CYC 4'h5
`define FBPO_MISS_MAX_CYC 4'h9
`define FBPO_COPY_CYC 6'h37
`define FBPO_ERASE_CYC 6'h20
`define FBPO_DROP_CYC 6'h02
// write threshold for the per page cycle count
`define FBPO_WR_THRESH 24'h0003E8
// page status word fields
`define FBPO_PS_OVR_BIT 3
`define FBPO_PS_RDP_BIT 2
`define FBPO_PS_WRP_BIT 1
`define FBPO_PS_GRD_BIT 0
`endif

//--- src/fbpo_ops.v
`include "fbpo_defines.vh"
// How it works
// [RL1] override sampled only with program or wipe
// [RL2] wipe strobe erases page to all zeros
// [RL3] guarded or loss-guarded foreign page: status 01
// [RL4] over threshold 11, uncorrectable 10 on wipe
// [RL5] reads from array, buffers, or status
// [RL6] read: corrected 01, uncorrected double error 10
// [RL7] info select with read returns page status
// [RL8] status word: count 31-8, bits 7-4 zero
// [RL9] bit 3 flags count over threshold
// [RL10] bits 2,1 show tap read/write protect
// [RL11] bit 0 guard; guarded page refuses writes
// [RL12] read-ahead fetches next linear block
// [RL13] last page block: fetch next page first
// [RL14] spare reads go next sector, wrap 0
// [RL15] aux reads go next page aux block
// [RL16] mispredict waits fetch, at most nine busy
// [RL17] clear strobe clears page guard
// [RL18] clear copies page unless buffer loss-guarded
// [RL19] copy: corrected 01, double error 10 kept
// [RL20] foreign, guarded, modified buffer: status 11
// [RL21] drop strobe marks buffer unmodified
// [RL22] busy held until drop completes
// [RL23] operations accepted only while busy low
// [RL24] status holds until next operation starts
module fbpo_ops (
  // clock and reset
  input wire clk_sys,
  input wire nrst,
  // operation strobes
  input wire read_strobe,
  input wire program_strobe,
  input wire page_wipe_strobe,
  input wire guard_clear_strobe,
  input wire buffer_drop_strobe,
  // operation options
  input wire [`FBPO_AW-1:0] addr,
  input wire destination_override,
  input wire buffer_loss_guard,
  input wire overwrite_guard_set,
  input wire read_ahead_select,
  input wire page_info_select,
  input wire spare_select,
  input wire aux_select,
  input wire pipe_mode,
  // array side condition inputs
  input wire ecc_single,
  input wire ecc_double,
  input wire tap_read_protect,
  input wire tap_write_protect,
  input wire [31:0] array_rdata,
  // results
  output reg busy_ff,
  output reg [1:0] status_ff,
  output reg [31:0] rdata_ff,
  output reg rvalid_ff,
  output reg buf_modified_ff,
  output reg [9:0] buf_page_ff
);
  localparam S_IDLE = 3'h0;
  localparam S_WAIT = 3'h1;
  localparam S_READ = 3'h2;
  localparam S_ERASE = 3'h3;
  localparam S_COPY = 3'h4;
  localparam S_DROP = 3'h5;

  //--------------------------------------------------------------
  // per page state, then sequencer registers
  //--------------------------------------------------------------
  reg [23:0] wcount_mem [0:`FBPO_NPAGES-1];
  reg [`FBPO_NPAGES-1:0] guard_ff;
  reg [`FBPO_NPAGES-1:0] wc_seen_ff;
  reg [2:0] state_ff;
  reg [5:0] cnt_ff;
  reg [`FBPO_AW-1:0] op_addr_ff;
  reg [`FBPO_AW-1:0] pred_ff;
  reg ahead_valid_ff;
  reg [3:0] fetch_left_ff;
  reg info_ff;
  reg err1_ff;
  reg err2_ff;

  wire [9:0] pg = addr[`FBPO_SEC_MSB:`FBPO_PG_LSB];
  wire [9:0] op_pg = op_addr_ff[`FBPO_SEC_MSB:`FBPO_PG_LSB];
  wire [3:0] blk = addr[`FBPO_BLK_MSB:`FBPO_BLK_LSB];
  wire [4:0] sec = addr[`FBPO_SEC_MSB:`FBPO_SEC_LSB];
  wire in_buf = (pg == buf_page_ff);
  wire [23:0] op_cnt = wc_seen_ff[op_pg] ? wcount_mem[op_pg] : 24'h000000;
  wire over_thr = (op_cnt > `FBPO_WR_THRESH);
  wire idle = !busy_ff; // see [RL23]
  wire any_op = read_strobe | program_strobe | page_wipe_strobe | guard_clear_strobe | buffer_drop_strobe;
  // override only looked at when a program or wipe is being accepted
  wire ovr_use = destination_override & (program_strobe | page_wipe_strobe); // see [RL1]
  // on a guard clear, loss guard blocks foreign pages only when the buffer carries edits
  wire loss_block = buffer_loss_guard & buf_modified_ff & !in_buf;

  //--------------------------------------------------------------
  // look-ahead address prediction
  //--------------------------------------------------------------
  reg [`FBPO_AW-1:0] nxt_pred;
  always @* begin
    nxt_pred = addr;
    if (aux_select) begin
      nxt_pred[`FBPO_SEC_MSB:`FBPO_PG_LSB] = pg + 10'h001; // see [RL15]
    end else if (spare_select) begin
      nxt_pred[`FBPO_SEC_MSB:`FBPO_SEC_LSB] = sec + 5'h01; // see [RL14] wraps to 0 naturally
      nxt_pred[`FBPO_BLK_MSB:`FBPO_BLK_LSB] = 4'h0;
    end else if (blk == `FBPO_LAST_BLK) begin
      nxt_pred[`FBPO_SEC_MSB:`FBPO_PG_LSB] = pg + 10'h001; // see [RL13]
      nxt_pred[`FBPO_BLK_MSB:`FBPO_BLK_LSB] = 4'h0;
    end else begin
      nxt_pred[`FBPO_BLK_MSB:`FBPO_BLK_LSB] = blk + 4'h1; // see [RL12]
    end
    nxt_pred[`FBPO_BLK_LSB-1:0] = 3'h0;
  end

  wire hit = ahead_valid_ff && (addr[`FBPO_AW-1:`FBPO_BLK_LSB] == pred_ff[`FBPO_AW-1:`FBPO_BLK_LSB]);

  //--------------------------------------------------------------
  // operation sequencer
  //--------------------------------------------------------------
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_ff <= S_IDLE;
      busy_ff <= 1'b0;
      status_ff <= `FBPO_ST_OK;
      rdata_ff <= 32'h00000000;
      rvalid_ff <= 1'b0;
      buf_modified_ff <= 1'b0;
      buf_page_ff <= 10'h000;
      guard_ff <= {`FBPO_NPAGES{1'b0}};
      cnt_ff <= 6'h00;
      op_addr_ff <= {`FBPO_AW{1'b0}};
      pred_ff <= {`FBPO_AW{1'b0}};
      ahead_valid_ff <= 1'b0;
      fetch_left_ff <= 4'h0;
      info_ff <= 1'b0;
      err1_ff <= 1'b0;
      err2_ff <= 1'b0;
    end else begin
      rvalid_ff <= 1'b0;
      // background look-ahead fetch drains while block buffer is read
      if (fetch_left_ff != 4'h0) begin
        fetch_left_ff <= fetch_left_ff - 4'h1;
      end
      case (state_ff)
        S_IDLE: begin
          if (idle && any_op) begin // see [RL23]
            op_addr_ff <= addr;
            status_ff <= `FBPO_ST_OK; // see [RL24] cleared only at a new start
            err1_ff <= 1'b0;
            err2_ff <= 1'b0;
            if (read_strobe) begin
              info_ff <= page_info_select; // see [RL7]
              busy_ff <= 1'b1;
              if (!page_info_select && read_ahead_select && hit) begin
                state_ff <= S_READ;
                cnt_ff <= {5'h00, pipe_mode}; // see [RL5]
              end else if (!page_info_select && read_ahead_select && fetch_left_ff != 4'h0) begin
                state_ff <= S_WAIT; // see [RL16]
                cnt_ff <= {2'h0, fetch_left_ff};
              end else begin
                state_ff <= S_READ;
                cnt_ff <= {2'h0, `FBPO_BLK_RD_CYC} + {5'h00, pipe_mode};
              end
              ahead_valid_ff <= read_ahead_select && !page_info_select;
              pred_ff <= nxt_pred;
              if (read_ahead_select && !page_info_select) begin
                fetch_left_ff <= `FBPO_BLK_RD_CYC; // see [RL12]
              end
            end else if (page_wipe_strobe) begin
              // guarded target, or foreign page under loss guard without override, is refused
              if (guard_ff[pg] || (buffer_loss_guard && !in_buf && !ovr_use)) begin
                status_ff <= `FBPO_ST_GUARD; // see [RL3]
              end else begin
                busy_ff <= 1'b1;
                state_ff <= S_ERASE; // see [RL2]
                cnt_ff <= `FBPO_ERASE_CYC;
              end
            end else if (program_strobe) begin
              // program itself lives outside; only the guard flag and the buffer page and modified flag are kept here
              if (guard_ff[pg]) begin
                status_ff <= `FBPO_ST_GUARD; // see [RL11]
              end else begin
                guard_ff[pg] <= overwrite_guard_set;
                buf_modified_ff <= 1'b0;
                if (ovr_use) begin
                  buf_page_ff <= pg; // see [RL1]
                end
              end
            end else if (guard_clear_strobe) begin
              guard_ff[pg] <= 1'b0; // see [RL17]
              if (loss_block) begin
                status_ff <= `FBPO_ST_LOSS; // see [RL20]
              end else if (!in_buf) begin
                busy_ff <= 1'b1;
                state_ff <= S_COPY; // see [RL18]
                cnt_ff <= `FBPO_COPY_CYC;
              end
            end else begin
              busy_ff <= 1'b1;
              state_ff <= S_DROP; // see [RL22]
              cnt_ff <= `FBPO_DROP_CYC;
            end
          end
        end
        S_WAIT: begin
          // pending fetch finishes, then a fresh block read
          if (cnt_ff <= 6'h01) begin
            state_ff <= S_READ;
            cnt_ff <= {2'h0, `FBPO_MISS_MAX_CYC} - {2'h0, `FBPO_BLK_RD_CYC} - 6'h01 + {5'h00, pipe_mode}; // see [RL16]
          end else begin
            cnt_ff <= cnt_ff - 6'h01;
          end
        end
        S_READ: begin
          if (cnt_ff == 6'h00) begin
            busy_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            state_ff <= S_IDLE;
            if (info_ff) begin
              rdata_ff <= {op_cnt, 4'h0, over_thr, tap_read_protect, tap_write_protect, guard_ff[op_pg]}; // see [RL8]
            end else begin
              rdata_ff <= array_rdata; // see [RL5]
              if (ecc_double) begin
                status_ff <= `FBPO_ST_DBE; // see [RL6]
              end else if (ecc_single) begin
                status_ff <= `FBPO_ST_SBE;
              end
            end
          end else begin
            cnt_ff <= cnt_ff - 6'h01;
          end
        end
        S_ERASE: begin
          err2_ff <= err2_ff | ecc_double;
          if (cnt_ff == 6'h00) begin
            busy_ff <= 1'b0;
            state_ff <= S_IDLE;
            if (over_thr) begin
              status_ff <= `FBPO_ST_THRESH; // see [RL4]
            end else if (err2_ff || ecc_double) begin
              status_ff <= `FBPO_ST_DBE;
            end
          end else begin
            cnt_ff <= cnt_ff - 6'h01;
          end
        end
        S_COPY: begin
          err1_ff <= err1_ff | ecc_single;
          err2_ff <= err2_ff | ecc_double;
          if (cnt_ff == 6'h00) begin
            busy_ff <= 1'b0;
            state_ff <= S_IDLE;
            buf_page_ff <= op_pg; // corrupted data stays loaded
            buf_modified_ff <= 1'b0;
            if (err2_ff || ecc_double) begin
              status_ff <= `FBPO_ST_DBE; // see [RL19]
            end else if (err1_ff || ecc_single) begin
              status_ff <= `FBPO_ST_SBE;
            end
          end else begin
            cnt_ff <= cnt_ff - 6'h01;
          end
        end
        S_DROP: begin
          if (cnt_ff == 6'h00) begin
            busy_ff <= 1'b0; // see [RL22]
            buf_modified_ff <= 1'b0; // see [RL21]
            state_ff <= S_IDLE;
          end else begin
            cnt_ff <= cnt_ff - 6'h01;
          end
        end
        default: begin
          state_ff <= S_IDLE;
          busy_ff <= 1'b0;
        end
      endcase
    end
  end

  //--------------------------------------------------------------
  // write count memory, bumped at the end of each wipe
  //--------------------------------------------------------------
  // the array has no reset, so a per page flag marks entries written at least
  // once and an unwritten page reads as a zero count instead of an unknown
  wire wc_we = (state_ff == S_ERASE) && (cnt_ff == 6'h00);
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wc_seen_ff <= {`FBPO_NPAGES{1'b0}};
    end else if (wc_we) begin
      wc_seen_ff[op_pg] <= 1'b1;
    end
  end
  // count written on the same edge that ends the wipe
  always @(posedge clk_sys) begin
    if (wc_we) begin
      wcount_mem[op_pg] <= op_cnt + 24'h000001; // see [RL9]
    end
  end
endmodule

//--- tb/fbpo_checker.sv
`include "fbpo_defines.vh"
module fbpo_checker (
  // clock and reset
  input wire clk_sys,
  input wire nrst,
  // operation requests
  input wire read_strobe,
  input wire program_strobe,
  input wire page_wipe_strobe,
  input wire guard_clear_strobe,
  input wire buffer_drop_strobe,
  input wire page_info_select,
  input wire tap_read_protect,
  input wire tap_write_protect,
  // results
  input wire busy_ff,
  input wire [1:0] status_ff,
  input wire [31:0] rdata_ff,
  input wire rvalid_ff,
  input wire buf_modified_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------
  // helpers
  // --------------------
  reg info_ff;
  wire any_stb = read_strobe | program_strobe | page_wipe_strobe | guard_clear_strobe | buffer_drop_strobe;
  // drop has the lowest priority, so it only runs when nothing else asks
  wire drop_only = buffer_drop_strobe & ~(any_stb & ~buffer_drop_strobe);
  // remember whether the read in flight returns the status word
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst)
      info_ff <= 1'b0;
    else if (!busy_ff && read_strobe)
      info_ff <= page_info_select;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence s_rd_go; !busy_ff && read_strobe; endsequence
  sequence s_drop_go; !busy_ff && drop_only; endsequence
  sequence s_drop_run; busy_ff[*3] ##1 (!busy_ff && !buf_modified_ff); endsequence
  sequence s_quiet; (!busy_ff && !any_stb)[*3]; endsequence
  property p_rd_busy; s_rd_go |=> busy_ff; endproperty
  property p_rd_bound; s_rd_go |-> ##[1:11] rvalid_ff; endproperty
  property p_rd_clear; s_rd_go |=> status_ff == `FBPO_ST_OK; endproperty
  property p_rv_pulse; rvalid_ff |=> !rvalid_ff; endproperty
  property p_rv_idle; rvalid_ff |-> !busy_ff; endproperty
  property p_info; rvalid_ff && info_ff |-> rdata_ff[7:4] == 4'h0
    && rdata_ff[2:1] == {tap_read_protect, tap_write_protect}; endproperty
  property p_drop; s_drop_go |=> s_drop_run; endproperty
  property p_hold; s_quiet |=> $stable(status_ff); endproperty
  a_rd_busy: assert property (p_rd_busy) else $error("read not taken while idle");
  a_rd_bound: assert property (p_rd_bound) else $error("read data late");
  a_rd_clear: assert property (p_rd_clear) else $error("status not cleared at start");
  a_rv_pulse: assert property (p_rv_pulse) else $error("read valid longer than a cycle");
  a_rv_idle: assert property (p_rv_idle) else $error("read valid while busy");
  a_info: assert property (p_info) else $error("status word fields wrong");
  a_drop: assert property (p_drop) else $error("drop busy or flag wrong");
  a_hold: assert property (p_hold) else $error("status moved while idle");
endmodule
bind fbpo_ops fbpo_checker u_chk (.clk_sys, .nrst, .read_strobe, .program_strobe, .page_wipe_strobe,
  .guard_clear_strobe, .buffer_drop_strobe, .page_info_select, .tap_read_protect, .tap_write_protect,
  .busy_ff, .status_ff, .rdata_ff, .rvalid_ff, .buf_modified_ff);

//--- tb/fbpo_fabric_array.sv
module fbpo_fabric_array (
  // address
  input wire [16:0] addr,
  // array word
  output wire [31:0] array_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // each address gets its own word, so a read from the wrong place shows
  assign array_rdata = {~addr[14:0], addr};
endmodule

//--- tb/tb_flash_block_page_ops_read.sv
module tb_flash_block_page_ops_read;
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------
  // stimulus
  // --------------------
  reg clk_sys = 1'b0;
  reg nrst = 1'b0;
  reg [4:0] stb = 5'h00; // drop, clear, wipe, program, read
  reg [9:0] opt = 10'h000; // ecc2, ecc1, pipe, aux, spare, info, ahead, guard, loss, override
  reg [16:0] addr = 17'h00000;
  wire [31:0] array_rdata;
  wire busy_ff;
  wire [1:0] status_ff;
  wire [31:0] rdata_ff;
  wire rvalid_ff;
  wire buf_modified_ff;
  wire [9:0] buf_page_ff;
  reg [1:0] tap = 2'h2; // read protect, write protect
  integer num_errors = 0;
  integer n_tests = 0;
  integer cyc;
  integer c0;
  integer i;
  reg [31:0] w0;
  localparam [4:0] RD = 5'h01, PG = 5'h02, WP = 5'h04, GC = 5'h08, DR = 5'h10;
  localparam [84:0] A1 = {17'h00000, 17'h00040, 17'h1F000, 17'h00038, 17'h00000};
  localparam [84:0] A2 = {17'h00280, 17'h000C0, 17'h00000, 17'h00080, 17'h00008};
  localparam [49:0] OA = {10'h008, 10'h048, 10'h028, 10'h008, 10'h008};
  fbpo_ops DUT (.clk_sys(clk_sys), .nrst(nrst), .read_strobe(stb[0]), .program_strobe(stb[1]),
    .page_wipe_strobe(stb[2]), .guard_clear_strobe(stb[3]), .buffer_drop_strobe(stb[4]), .addr(addr),
    .destination_override(opt[0]), .buffer_loss_guard(opt[1]), .overwrite_guard_set(opt[2]),
    .read_ahead_select(opt[3]), .page_info_select(opt[4]), .spare_select(opt[5]), .aux_select(opt[6]),
    .pipe_mode(opt[7]), .ecc_single(opt[8]), .ecc_double(opt[9]), .tap_read_protect(tap[1]),
    .tap_write_protect(tap[0]), .array_rdata(array_rdata), .busy_ff(busy_ff), .status_ff(status_ff),
    .rdata_ff(rdata_ff), .rvalid_ff(rvalid_ff), .buf_modified_ff(buf_modified_ff), .buf_page_ff(buf_page_ff));
  fbpo_fabric_array u_far (.addr(addr), .array_rdata(array_rdata));
  initial forever #4 clk_sys = ~clk_sys;
  function [31:0] word(input [16:0] a);
    word = {~a[14:0], a};
  endfunction
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one strobe with its levels, count busy cycles, then let late status land
  task op(input [4:0] s, input [16:0] a, input [9:0] o);
    @(posedge clk_sys);
    stb <= s;
    addr <= a;
    opt <= o;
    @(posedge clk_sys);
    stb <= 5'h00;
    @(negedge clk_sys);
    cyc = 0;
    while (busy_ff === 1'b1 && cyc < 200) begin
      @(negedge clk_sys);
      cyc = cyc + 1;
    end
    repeat (2) @(negedge clk_sys);
  endtask
  task t_read;
    op(RD, 17'h00A48, 10'h001);
    c0 = cyc;
    check(rdata_ff, word(17'h00A48));
    check(status_ff, 2'h0);
    check(cyc <= 9, 1'b1);
    op(RD, 17'h00A48, 10'h100);
    check(status_ff, 2'h1);
    op(RD, 17'h00A48, 10'h200);
    check(status_ff, 2'h2);
    op(RD, 17'h00A48, 10'h080);
    check(status_ff, 2'h0);
    check(cyc, c0 + 1);
  endtask
  task t_guard;
    op(PG, 17'h00000, 10'h004);
    op(RD, 17'h00000, 10'h010);
    w0 = rdata_ff;
    check(rdata_ff[7:0], 8'h05);
    op(WP, 17'h00000, 10'h000);
    check({status_ff, cyc[5:0]}, 8'h40);
    op(GC, 17'h00000, 10'h000);
    // flip both protect pins so the status word must follow them
    @(posedge clk_sys);
    tap <= 2'h1;
    op(RD, 17'h00000, 10'h010);
    check(rdata_ff[0], 1'b0);
    check(rdata_ff[2:1], 2'h1);
    op(WP, 17'h00000, 10'h000);
    check({status_ff, cyc[5:0]}, 8'h21);
    op(RD, 17'h00000, 10'h010);
    check(rdata_ff[31:8], w0[31:8] + 24'h000001);
  endtask
  task t_buffer;
    op(DR, 17'h00000, 10'h000);
    check({cyc[3:0], buf_modified_ff}, 5'h06);
    op(GC, 17'h00100, 10'h100);
    check({status_ff, cyc[5:0]}, 8'h78);
    op(GC, 17'h00180, 10'h200);
    check(status_ff, 2'h2);
    check(buf_page_ff, 10'h003);
    op(WP, 17'h00080, 10'h002);
    check(status_ff, 2'h1);
  endtask
  // predicted follow-up reads wait at most a cycle, a mispredict waits longer
  task t_ahead;
    for (i = 0; i < 5; i = i + 1) begin
      op(RD, A1[i*17 +: 17], OA[i*10 +: 10]);
      check(cyc <= 9, 1'b1);
      repeat (6) @(negedge clk_sys);
      op(RD, A2[i*17 +: 17], OA[i*10 +: 10]);
      check(cyc <= 1, i < 4);
      check(cyc <= 9, 1'b1);
      if (OA[i*10 +: 10] == 10'h008)
        check(rdata_ff, word(A2[i*17 +: 17]));
    end
  endtask
  task conclude;
    $display("errors %0d of %0d checks", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // the whole run needs a few hundred cycles, so this only trips on a hang
  initial begin
    #200us;
    num_errors = num_errors + 1;
    conclude;
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    @(negedge clk_sys);
    check({busy_ff, status_ff, rvalid_ff, buf_modified_ff}, 5'h00);
    t_read;
    t_guard;
    t_buffer;
    t_ahead;
    conclude;
  end
endmodule
